// *** hdl/mil_consts.svh ***
/*
 * Constants of the interrupt request logic: register offsets, bit positions,
 * reset values and timing counts.
 * Assumes inclusion by bare name from the package and the design module.
 */
// Overview of operation
// - Each flag sets on its event regardless of its enable or global enable.
// - Control bit 7 is the global enable; enabled pending flag vectors after the entry latency.
// - Every reset clears the global enable bit.
// - Taking an interrupt clears global enable, pushes return address, loads 0004h.
// - Return-from-interrupt instruction sets the global enable again.
// - Peripheral flags and enables in own registers; control bit 6 gates them all.
// - External events reach the vector after three or four instruction cycles.
// - Latency is independent of one or two cycle instructions in progress.
// - External pin is edge triggered; option bit 6 picks rising when set.
// - Valid pin edge sets control bit 1; control bit 4 enables it.
// - Pin interrupt wakes sleep if enabled; global enable decides the branch.
// - Timer0 rollover FFh to 00h sets control bit 2; bit 5 enables it.
// - Change on port B pins 7:4 sets control bit 0; own enable gates it.
// - Entry saves only the return program counter; no working or status save.
// - Wake by interrupt with global enable set loads vector 0004h.
// - Wake-up leaves flags and enables unchanged except the waking flags.
// - Wake with global enable clear resumes after the sleep instruction.
`ifndef MIL_CONSTS_SVH
`define MIL_CONSTS_SVH

// Register byte offsets on the bus
`define MIL_OFF_CONTROL 4'h0
`define MIL_OFF_OPTION 4'h4
`define MIL_OFF_PFLAG1 4'h8
`define MIL_OFF_PFLAG2 4'hC
`define MIL_ADDR_W 4

// Control and option register bit positions
`define MIL_B_GIE 7
`define MIL_B_PEIE 6
`define MIL_B_TIMER0_OVERFLOW_ENABLE 5
`define MIL_B_EXIE 4
`define MIL_B_PCIE 3
`define MIL_B_TIMER0_OVERFLOW_FLAG 2
`define MIL_B_EXIF 1
`define MIL_B_PCIF 0
`define MIL_B_EDGE 6

// Reset values
`define MIL_RST_CONTROL 8'h00
`define MIL_RST_OPTION 8'hFF
`define MIL_RST_PENABLE 8'h00

// Vector and timing
`define MIL_VECTOR 13'h0004
`define MIL_CLK_NS 10
`define MIL_ICYC_NS 200
`define MIL_ICYC_CLKS (`MIL_ICYC_NS / `MIL_CLK_NS)
`define MIL_LAT_ICYC 4

`endif

// *** hdl/mil_irq_logic.sv ***
/*
 * Interrupt request logic of a small 8-bit controller with an AXI4-Lite
 * register port for the control, option and peripheral registers.
 * Assumes inputs synchronous to aclk except the pin and port lines, and a
 * core that pushes the return address when asked and reports its state.
 */
`timescale 1ns/1ps
`include "mil_consts.svh"
module mil_irq_logic #(
  parameter int NPERIPH = 8,
  parameter int ICYC_CLKS = `MIL_ICYC_CLKS
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [`MIL_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [`MIL_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Interrupt sources
  input wire logic ext_irq_pin,
  input wire logic [3:0] port_b_pins,
  input wire logic timer0_rollover,
  input wire logic [NPERIPH-1:0] periph_event,
  // Core side
  input wire logic return_from_irq_instr,
  input wire logic sleeping,
  output mil_pkg::mil_vec_s core_vec,
  output logic wake
);
  import mil_pkg::*;

  logic [7:0] irq_control;
  logic [7:0] option_reg;
  logic [NPERIPH-1:0] periph_flag_reg1;
  logic [NPERIPH-1:0] periph_enable_reg1;
  logic ext_s1, ext_s2, ext_d;
  logic [3:0] pb_s1, pb_s2, pb_d;
  logic ext_edge, port_change;
  logic any_pending, periph_pending;
  mil_state_e state;
  logic [7:0] lat_cnt;
  logic [1:0] icyc_left;
  logic aw_held, w_held;
  logic [`MIL_ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire, wr_ctl, wr_opt, wr_pf, wr_pe;
  logic [7:0] ctl_clr;
  logic take_now;

  // Entry window in clocks, counted from the first cycle spent waiting
  localparam int LAT_MIN = (`MIL_LAT_ICYC - 1) * ICYC_CLKS + 1;
  localparam int LAT_MAX = `MIL_LAT_ICYC * ICYC_CLKS;

  // two-stage synchronisers
  // Reset loads the pin levels, so release never shows a false edge or change
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_s1 <= ext_irq_pin;
      ext_s2 <= ext_irq_pin;
      ext_d <= ext_irq_pin;
      pb_s1 <= port_b_pins;
      pb_s2 <= port_b_pins;
      pb_d <= port_b_pins;
    end else begin
      ext_s1 <= ext_irq_pin;
      ext_s2 <= ext_s1;
      ext_d <= ext_s2;
      pb_s1 <= port_b_pins;
      pb_s2 <= pb_s1;
      pb_d <= pb_s2;
    end
  end

  assign ext_edge = option_reg[`MIL_B_EDGE] ? (ext_s2 & ~ext_d) : (~ext_s2 & ext_d);
  assign port_change = |(pb_s2 ^ pb_d);

  // Write channel capture; address and data may arrive in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0;
      w_strb <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held <= 1'b0;
      end
    end
  end

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_fire = aw_held && w_held;
  assign wr_ctl = wr_fire && w_strb[0] && aw_addr == `MIL_OFF_CONTROL;
  assign wr_opt = wr_fire && w_strb[0] && aw_addr == `MIL_OFF_OPTION;
  assign wr_pf = wr_fire && w_strb[0] && aw_addr == `MIL_OFF_PFLAG1;
  assign wr_pe = wr_fire && w_strb[0] && aw_addr == `MIL_OFF_PFLAG2;

  // Write response, unmapped offsets answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr[1:0] != 2'b00) ? 2'b10 : 2'b00;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Read channel, one cycle answer
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= 2'b00;
      unique case (s_axi_araddr)
        `MIL_OFF_CONTROL: s_axi_rdata <= {24'h0, irq_control};
        `MIL_OFF_OPTION: s_axi_rdata <= {24'h0, option_reg};
        `MIL_OFF_PFLAG1: s_axi_rdata <= 32'(periph_flag_reg1);
        `MIL_OFF_PFLAG2: s_axi_rdata <= 32'(periph_enable_reg1);
        default: begin
          s_axi_rdata <= 32'h0;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Option register, edge select lives in bit 6
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      option_reg <= `MIL_RST_OPTION;
    end else if (wr_opt) begin
      option_reg <= w_data[7:0];
    end
  end

  // Flag bits cleared by writing zero; a set in the same cycle wins
  assign ctl_clr = wr_ctl ? ~w_data[7:0] : 8'h00;
  assign take_now = state == MIL_ENTRY;

  // Control register: enables written by software, flags set by hardware
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_control <= `MIL_RST_CONTROL;
    end else begin
      if (wr_ctl) begin
        irq_control[7:3] <= w_data[7:3];
      end
      if (take_now) begin
        irq_control[`MIL_B_GIE] <= 1'b0;
      end else if (return_from_irq_instr) begin
        irq_control[`MIL_B_GIE] <= 1'b1;
      end
      irq_control[`MIL_B_EXIF] <= ext_edge | (irq_control[`MIL_B_EXIF] & ~ctl_clr[`MIL_B_EXIF]);
      irq_control[`MIL_B_TIMER0_OVERFLOW_FLAG] <= timer0_rollover | (irq_control[`MIL_B_TIMER0_OVERFLOW_FLAG] & ~ctl_clr[`MIL_B_TIMER0_OVERFLOW_FLAG]);
      irq_control[`MIL_B_PCIF] <= port_change | (irq_control[`MIL_B_PCIF] & ~ctl_clr[`MIL_B_PCIF]);
    end
  end

  genvar gi;
  for (gi = 0; gi < NPERIPH; gi++) begin : g_periph
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        periph_flag_reg1[gi] <= 1'b0;
        periph_enable_reg1[gi] <= 1'b0;
      end else begin
        periph_flag_reg1[gi] <= periph_event[gi] | (periph_flag_reg1[gi] & ~(wr_pf & ~w_data[gi]));
        if (wr_pe) begin
          periph_enable_reg1[gi] <= w_data[gi];
        end
      end
    end
  end

  assign periph_pending = irq_control[`MIL_B_PEIE] & |(periph_flag_reg1 & periph_enable_reg1);
  assign any_pending = (irq_control[`MIL_B_EXIF] & irq_control[`MIL_B_EXIE])
    | (irq_control[`MIL_B_TIMER0_OVERFLOW_FLAG] & irq_control[`MIL_B_TIMER0_OVERFLOW_ENABLE])
    | (irq_control[`MIL_B_PCIF] & irq_control[`MIL_B_PCIE]) | periph_pending;

  // enabled pending source wakes sleep; no register changes
  assign wake = sleeping & any_pending;

  // Instruction cycle counter; entry aligns to instruction boundaries
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lat_cnt <= 8'h0;
    end else if (lat_cnt == 8'(ICYC_CLKS - 1)) begin
      lat_cnt <= 8'h0;
    end else begin
      lat_cnt <= lat_cnt + 8'h1;
    end
  end

  // Vectoring sequence
  // three to four instruction-cycle latency after a pending request
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= MIL_RUN;
      icyc_left <= 2'h0;
    end else begin
      unique case (state)
        MIL_RUN: begin
          // global enable gates vectoring; also after wake
          if (irq_control[`MIL_B_GIE] && any_pending && !sleeping) begin
            state <= MIL_SYNC;
            icyc_left <= 2'(`MIL_LAT_ICYC - 1);
          end
        end
        MIL_SYNC: begin
          if (lat_cnt == 8'(ICYC_CLKS - 1)) begin
            if (icyc_left == 2'h0) begin
              state <= MIL_ENTRY;
            end else begin
              icyc_left <= icyc_left - 2'h1;
            end
          end
        end
        MIL_ENTRY: state <= MIL_RUN;
      endcase
    end
  end

  // vector and push request; only the return address is saved
  // with global enable clear no vector follows wake
  assign core_vec.take = take_now;
  assign core_vec.push = take_now;
  assign core_vec.vector = `MIL_VECTOR;

  AST_GIE_RESET: assert property (@(posedge aclk) !aresetn |=> !irq_control[`MIL_B_GIE])
    else $error("global enable not cleared by reset");
  AST_ENTRY_CLEARS: assert property (@(posedge aclk) disable iff (!aresetn)
    take_now |=> !irq_control[`MIL_B_GIE])
    else $error("global enable left set after entry");
  AST_TAKE_PULSE: assert property (@(posedge aclk) disable iff (!aresetn)
    take_now |=> !take_now)
    else $error("entry request longer than one cycle");
  AST_RETURN_SETS: assert property (@(posedge aclk) disable iff (!aresetn)
    return_from_irq_instr && !take_now |=> irq_control[`MIL_B_GIE])
    else $error("return did not re-enable");
  // enable rises only by return or write
  AST_GIE_SOURCE: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(irq_control[`MIL_B_GIE]) |-> $past(return_from_irq_instr) || $past(wr_ctl))
    else $error("global enable set without return or write");
  AST_EXT_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
    ext_edge |=> irq_control[`MIL_B_EXIF])
    else $error("pin edge did not set flag");
  AST_EXT_ONCE: assert property (@(posedge aclk) disable iff (!aresetn)
    ext_edge && !wr_opt |=> !ext_edge)
    else $error("pin edge seen twice");
  AST_T0_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
    timer0_rollover |=> irq_control[`MIL_B_TIMER0_OVERFLOW_FLAG])
    else $error("timer rollover did not set flag");
  AST_PC_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
    $changed(pb_s2) && $past(aresetn) |=> irq_control[`MIL_B_PCIF])
    else $error("port change did not set flag");
  AST_PERIPH_FLAG: assert property (@(posedge aclk) disable iff (!aresetn)
    |periph_event |=> (periph_flag_reg1 & $past(periph_event)) == $past(periph_event))
    else $error("peripheral event did not set flag");
  AST_NO_TAKE_DISABLED: assert property (@(posedge aclk) disable iff (!aresetn)
    state == MIL_RUN && !irq_control[`MIL_B_GIE] |=> state == MIL_RUN)
    else $error("vectoring while globally disabled");
  AST_GIE_STARTS: assert property (@(posedge aclk) disable iff (!aresetn)
    state == MIL_RUN && irq_control[`MIL_B_GIE] && any_pending && !sleeping |=> state == MIL_SYNC)
    else $error("enabled request did not start entry");
  AST_VECTOR: assert property (@(posedge aclk) disable iff (!aresetn)
    core_vec.take |-> core_vec.vector == 13'h0004 && core_vec.push)
    else $error("wrong vector on entry");
  AST_WAKE: assert property (@(posedge aclk) disable iff (!aresetn)
    sleeping && irq_control[`MIL_B_EXIF] && irq_control[`MIL_B_EXIE] |-> wake)
    else $error("enabled pin flag failed to wake");
  AST_NO_TAKE_ASLEEP: assert property (@(posedge aclk) disable iff (!aresetn)
    state == MIL_RUN && sleeping |=> state == MIL_RUN)
    else $error("entry started during sleep");
  AST_SLEEP_KEEPS: assert property (@(posedge aclk) disable iff (!aresetn)
    sleeping && !wr_ctl && !take_now && !return_from_irq_instr |=> $stable(irq_control[`MIL_B_GIE:`MIL_B_PCIE]))
    else $error("enables changed during sleep");
  AST_LATENCY: assert property (@(posedge aclk) disable iff (!aresetn)
    state == MIL_RUN && $past(state) == MIL_RUN ##1 state == MIL_SYNC
      |-> ##[LAT_MIN:LAT_MAX] state == MIL_ENTRY)
    else $error("entry latency out of range");
endmodule : mil_irq_logic

// *** hdl/mil_pkg.sv ***
/*
 * Types of the interrupt request logic.
 * Assumes the constants header is on the include path.
 */
`include "mil_consts.svh"
package mil_pkg;
  typedef enum logic [1:0] {MIL_RUN, MIL_SYNC, MIL_ENTRY} mil_state_e;
  // Core-facing vector request
  typedef struct packed {
    logic take;
    logic [12:0] vector;
    logic push;
  } mil_vec_s;
endpackage : mil_pkg

// *** test/mil_core_model.sv ***
/* Core stand-in: pushes the return address on a vector request, pops it on return.
   Assumes the bench commands returns and the interrupt logic pulses take. */
`timescale 1ns/1ps
module mil_core_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Interrupt logic side
  input wire mil_pkg::mil_vec_s core_vec,
  output logic return_from_irq_instr,
  // Bench side
  input wire logic ret_cmd,
  output logic [12:0] pc,
  output logic [3:0] depth,
  output logic [7:0] take_cnt
);
  import mil_pkg::*;
  logic [12:0] stack [0:7];
  // push pc + 1 only, pop on return
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pc <= 13'h0100;
      depth <= 4'h0;
      take_cnt <= 8'h00;
      return_from_irq_instr <= 1'b0;
    end else begin
      return_from_irq_instr <= ret_cmd;
      if (core_vec.take) begin
        stack[depth[2:0]] <= pc + 13'h0001;
        pc <= core_vec.vector;
        depth <= depth + 4'h1;
        take_cnt <= take_cnt + 8'h01;
      end else if (ret_cmd && depth != 4'h0) begin
        pc <= stack[depth[2:0] - 3'h1];
        depth <= depth - 4'h1;
      end
    end
  end
endmodule : mil_core_model

// *** test/mil_irq_logic_tb.sv ***
/* Bench for the interrupt request logic: register tasks over AXI4-Lite and scenarios.
   Assumes the design package is compiled first. */
`timescale 1ns/1ps
module mil_irq_logic_tb;
  import mil_pkg::*;
  localparam int IC = 4;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF, port_b_pins = 4'h0, depth;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, wake, return_from_irq_instr;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic ext_irq_pin = 1'b0, timer0_rollover = 1'b0, sleeping = 1'b0, ret_cmd = 1'b0;
  logic [7:0] periph_event = 8'h00, take_cnt, t0;
  logic [12:0] pc;
  mil_vec_s core_vec;
  int fails = 0;
  int samples_checked = 0;
  int n;
  mil_irq_logic #(.NPERIPH(8), .ICYC_CLKS(IC)) u_mil_irq_logic (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .ext_irq_pin(ext_irq_pin), .port_b_pins(port_b_pins), .timer0_rollover(timer0_rollover),
    .periph_event(periph_event), .return_from_irq_instr(return_from_irq_instr), .sleeping(sleeping),
    .core_vec(core_vec), .wake(wake)
  );
  mil_core_model u_mil_core_model (
    .aclk(aclk), .aresetn(aresetn), .core_vec(core_vec), .return_from_irq_instr(return_from_irq_instr),
    .ret_cmd(ret_cmd), .pc(pc), .depth(depth), .take_cnt(take_cnt)
  );
  // Free-running 100 MHz clock
  always #5 aclk = ~aclk;
  task automatic results;
    $display("checks %0d fails %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t %s got %h", $time, m, got);
    end
  endtask : chk
  task automatic to_chk;
    if (n >= 60) begin
      fails++;
      $display("[FAIL] %0t bus wait timed out", $time);
      results();
    end
  endtask : to_chk
  // Write one word; entered just after a rising edge
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h000000, v};
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ad && wd) && n < 60) begin
      @(negedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready) ad = 1'b1;
      if (s_axi_wvalid && s_axi_wready) wd = 1'b1;
      @(posedge aclk);
      if (ad) s_axi_awvalid <= 1'b0;
      if (wd) s_axi_wvalid <= 1'b0;
    end
    do begin @(negedge aclk); n++; end while (!s_axi_bvalid && n < 60);
    r = s_axi_bresp;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    @(posedge aclk);
    to_chk();
  endtask : wr
  task automatic rd(input logic [3:0] a);
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin @(negedge aclk); n++; end while (!s_axi_arready && n < 60);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do begin @(negedge aclk); n++; end while (!s_axi_rvalid && n < 60);
    d = s_axi_rdata;
    r = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    @(posedge aclk);
    to_chk();
  endtask : rd
  task automatic rc(input logic [3:0] a, input logic [7:0] e, input string m);
    rd(a);
    chk(d, {24'h000000, e}, m);
  endtask : rc
  task automatic pin(input logic v);
    ext_irq_pin <= v;
    repeat (6) @(posedge aclk);
  endtask : pin
  // Vector request must land inside the instruction-cycle window
  task automatic wait_take;
    @(negedge aclk);
    t0 = take_cnt;
    n = 0;
    do begin @(negedge aclk); n++; end while (take_cnt === t0 && n < 4 * IC + 4);
    chk(n >= 3 * IC && n <= 4 * IC + 2, 1, "latency");
    chk(pc, 13'h0004, "vector pc");
    @(posedge aclk);
  endtask : wait_take
  task automatic hold;
    @(negedge aclk);
    t0 = take_cnt;
    repeat (4 * IC) @(negedge aclk);
    chk(take_cnt, t0, "no vector");
    @(posedge aclk);
  endtask : hold
  // Main sequence
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(4'h0, 8'h00, "ctl reset");
    rc(4'h4, 8'hFF, "opt reset");
    timer0_rollover <= 1'b1;
    @(posedge aclk);
    timer0_rollover <= 1'b0;
    repeat (3) @(posedge aclk);
    rc(4'h0, 8'h04, "timer flag");
    wr(4'h0, 8'h00);
    pin(1'b1);
    rc(4'h0, 8'h02, "rise");
    wr(4'h4, 8'hBF);
    wr(4'h0, 8'h00);
    pin(1'b0);
    rc(4'h0, 8'h02, "fall");
    wr(4'h0, 8'h00);
    pin(1'b1);
    rc(4'h0, 8'h00, "wrong edge");
    port_b_pins <= 4'h5;
    repeat (6) @(posedge aclk);
    rc(4'h0, 8'h01, "port change");
    wr(4'h0, 8'h00);
    periph_event <= 8'h01;
    @(posedge aclk);
    periph_event <= 8'h00;
    repeat (3) @(posedge aclk);
    rc(4'h8, 8'h01, "periph flag");
    wr(4'hC, 8'h01);
    wr(4'h0, 8'h80);
    hold();
    wr(4'h0, 8'hC0);
    wait_take();
    rc(4'h0, 8'h40, "gie cleared");
    chk(depth, 4'h1, "one push");
    wr(4'h8, 8'h00);
    ret_cmd <= 1'b1;
    @(posedge aclk);
    ret_cmd <= 1'b0;
    repeat (2) @(posedge aclk);
    rc(4'h0, 8'hC0, "gie back");
    chk(pc, 13'h0101, "return pc");
    hold();
    // Mid-run reset with the pin high and port lines set: no false flags
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(4'h0, 8'h00, "ctl after reset");
    rc(4'h4, 8'hFF, "opt after reset");
    wr(4'h4, 8'hBF);
    wr(4'hC, 8'h00);
    sleeping <= 1'b1;
    wr(4'h0, 8'h10);
    pin(1'b0);
    @(negedge aclk);
    chk(wake, 1'b1, "wake");
    @(posedge aclk);
    rc(4'h0, 8'h12, "sleep flags");
    sleeping <= 1'b0;
    hold();
    wr(4'h0, 8'h10);
    pin(1'b1);
    sleeping <= 1'b1;
    wr(4'h0, 8'h90);
    pin(1'b0);
    hold();
    sleeping <= 1'b0;
    wait_take();
    rd(4'h2);
    chk(r, 2'b10, "unmapped read");
    wr(4'h1, 8'h00);
    chk(r, 2'b10, "unaligned write");
    results();
  end
endmodule : mil_irq_logic_tb
